// ---- rtl/msq_pkg.sv ----
// constants shared by the measurement sequencer and its testbench
// assumes a single 10 MHz clock and an active-low asynchronous reset
//
// Operation
// RL1 - id press starts event, drives to fiducial 1
// RL2 - nine fiducials: 1..8 then 2, views paired
// RL3 - track done ends fiducials, go to vertex
// RL4 - event done accepted only after all vertices
// RL5 - fiducial section: enable, counter reset, trigger
// RL6 - converter picks relay matching fiducial count
// RL7 - fiducial press advances counter and triggers
// RL8 - view counter loads 2, wraps 0 to 2
// RL9 - fiducial, vertex, zone triggers set automatic mode
// RL10 - encoder pulses hold auto, drop below 250 Hz
// RL11 - joystick clears automatic mode
// RL12 - clutches engaged while a track is measured
// RL13 - vertex complete pulses counters, enables event done
// RL14 - id loads down count, up count to one
// RL15 - view 2 then 3 and 1, reload per view
// RL16 - return and done enables only on last vertex
// RL17 - energize card column of current vertex zone
// RL18 - card opened early raises event discard
// RL19 - vertex complete drives stage to next zone
// RL20 - display totals, vertex, measurement, view
// RL21 - buttons synchronized, one pulse per press
package msq_pkg;

  // clock and automatic-mode drop-out timing
  localparam int CLK_HZ = 10_000_000; // system clock rate
  localparam int AUTO_DROP_HZ = 250; // encoder rate below which auto drops
  localparam int AUTO_HOLD_CYCLES = CLK_HZ / AUTO_DROP_HZ; // one period, rounded down

  // fiducial phase sizing
  localparam int FID_STEPS = 9; // measurements per event
  localparam logic [3:0] FID_FIRST = 4'h1; // counter reset value

  // view counter values
  localparam logic [1:0] VIEW_LOAD = 2'h2; // load value at id and at wrap
  localparam logic [1:0] VIEW_LAST = 2'h1; // final view of the rotation
  localparam logic [1:0] VIEW_WRAP = 2'h0; // value that fires the reload

  // vertex up counter start
  localparam int VTX_UP_FIRST = 1;

  // sequencer phases, gray along idle -> fiducial -> vertex -> finish
  typedef enum logic [1:0] {
    MSQ_IDLE = 2'b00,
    MSQ_FID = 2'b01,
    MSQ_VTX = 2'b11,
    MSQ_FIN = 2'b10
  } msq_state_e;

  // fiducial number for each measurement step
  function automatic logic [3:0] msq_fid_num(input logic [3:0] step);
    logic [3:0] n;
    n = 4'h2;
    if (step < 4'h8) n = step + 4'h1;
    return n;
  endfunction

  // view paired with each fiducial step; step 8 continues the rotation
  function automatic logic [1:0] msq_fid_view(input logic [3:0] step);
    logic [1:0] v;
    case (step)
      4'h0: v = 2'h2;
      4'h1: v = 2'h3;
      4'h2: v = 2'h1;
      4'h3: v = 2'h3;
      4'h4: v = 2'h1;
      4'h5: v = 2'h2;
      4'h6: v = 2'h3;
      4'h7: v = 2'h1;
      default: v = 2'h2;
    endcase
    return v;
  endfunction

endpackage

// ---- rtl/msq_edge.sv ----
// three-stage input conditioner with rising-edge pulse per bit
// assumes inputs are synchronous to clk; stage one feeds stage two only
`timescale 1ns/1ns
module msq_edge #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] level,
  output logic [W-1:0] rise
);

  ////////////////////////////////////////////////////////////////////////////
  // one conditioner per input bit
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic s1_q; // first stage, read only by s2_q
      logic s2_q; // settled level
      logic s3_q; // previous settled level

      // shift chain; edge taken between stages two and three
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
        end else begin
          s1_q <= din[i];
          s2_q <= s1_q;
          s3_q <= s2_q;
        end
      end

      assign level[i] = s2_q;
      assign rise[i] = s2_q & ~s3_q; // one cycle per press
    end
  endgenerate

endmodule // msq_edge

// ---- rtl/msq_sequencer.sv ----
// measurement sequencer: fiducial phase, vertex phase, auto stage triggers
// assumes buttons are level-high while pressed and encoder pulses are one cycle
`timescale 1ns/1ns
module msq_sequencer #(
  parameter int VW = 4, // vertex count width from the card
  parameter int AUTO_HOLD = msq_pkg::AUTO_HOLD_CYCLES // auto drop-out timeout
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic master_clear,
  input wire logic indicative_data_strobe,
  input wire logic fiducial_press,
  input wire logic track_done,
  input wire logic vertex_complete,
  input wire logic event_done,
  input wire logic stage_hold,
  input wire logic card_open,
  input wire logic joystick_active,
  input wire logic x_add,
  input wire logic x_sub,
  input wire logic y_add,
  input wire logic y_sub,
  input wire logic [VW-1:0] card_vertex_count,
  output logic converter_enable,
  output logic fid_counter_reset,
  output logic fiducial_trigger,
  output logic vertex_trigger,
  output logic zone_trigger,
  output logic [3:0] fiducial_count,
  output logic [3:0] fiducial_relay,
  output logic auto_mode,
  output logic clutch_engage,
  output logic event_discard,
  output logic event_done_enable,
  output logic fiducial_return_enable,
  output logic cycle_end,
  output logic [1:0] view_number,
  output logic [VW-1:0] vertex_total,
  output logic [VW-1:0] vertex_up,
  output logic [VW-1:0] vertex_down,
  output logic [3:0] measurement_number,
  output logic [VW-1:0] zone_column,
  output logic zone_column_en
);
  import msq_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // elaboration checks
  generate
    if (VW < 2 || VW > 8) begin : g_bad_vw
      $error("msq_sequencer: VW must be 2..8");
    end
    if (AUTO_HOLD < 2) begin : g_bad_hold
      $error("msq_sequencer: AUTO_HOLD must be at least 2");
    end
  endgenerate

  localparam int HW = $clog2(AUTO_HOLD + 1); // hold counter width
  localparam logic [HW-1:0] HOLD_LOAD = HW'(AUTO_HOLD);
  localparam logic [VW-1:0] UP_FIRST = VW'(VTX_UP_FIRST);
  localparam logic [3:0] FID_LAST = 4'(FID_STEPS);

  ////////////////////////////////////////////////////////////////////////////
  // button conditioning
  logic [6:0] btn_lvl; // settled levels
  logic [6:0] btn_rise; // one-cycle presses

  msq_edge #(.W(7)) i_msq_edge (
    .clk(clk),
    .rst_n(rst_n),
    .din({card_open, event_done, vertex_complete, track_done,
          fiducial_press, indicative_data_strobe, master_clear}),
    .level(btn_lvl),
    .rise(btn_rise)
  ); // RL21

  logic mc_p; // master clear press
  logic id_p; // indicative data press
  logic fid_p; // fiducial measured
  logic td_p; // track done press
  logic vc_p; // vertex complete press
  logic ed_p; // event done press
  logic open_p; // card reader opened
  assign mc_p = btn_rise[0];
  assign id_p = btn_rise[1];
  assign fid_p = btn_rise[2];
  assign td_p = btn_rise[3];
  assign vc_p = btn_rise[4];
  assign ed_p = btn_rise[5];
  assign open_p = btn_rise[6];

  ////////////////////////////////////////////////////////////////////////////
  // phase state
  msq_state_e state_q; // current phase
  msq_state_e state_d;
  logic [3:0] step_q; // fiducial measurements taken
  logic last_vtx; // last vertex of final view under way
  logic vtx_wrap; // vertex complete empties the down counter
  logic all_meas_q; // every vertex measured
  logic discard; // early card open

  assign last_vtx = (state_q == MSQ_VTX) && (view_number == VIEW_LAST)
                    && (vertex_down == UP_FIRST) && !all_meas_q;
  assign vtx_wrap = (state_q == MSQ_VTX) && vc_p && !all_meas_q
                    && (vertex_down == UP_FIRST);
  // card opened any time between id and event end
  assign discard = open_p && (state_q != MSQ_IDLE); // RL18

  // next phase
  always_comb begin
    state_d = state_q;
    case (state_q)
      MSQ_IDLE: begin
        if (id_p && btn_lvl[6] == 1'b0) state_d = MSQ_FID; // RL1
      end
      MSQ_FID: begin
        if (td_p && step_q == FID_LAST) state_d = MSQ_VTX; // RL3
      end
      MSQ_VTX: begin
        if (ed_p && all_meas_q) state_d = MSQ_FIN; // RL4
      end
      default: begin
        state_d = MSQ_IDLE; // one cycle to report the end
      end
    endcase
    if (discard) state_d = MSQ_IDLE;
  end

  // phase register; master clear aborts like a reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= MSQ_IDLE;
    end else if (mc_p) begin
      state_q <= MSQ_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // end-of-cycle and discard pulses
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cycle_end <= 1'b0;
      event_discard <= 1'b0;
    end else begin
      cycle_end <= (state_q == MSQ_VTX) && (state_d == MSQ_FIN) && !mc_p; // RL4
      event_discard <= discard && !mc_p; // RL18
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fiducial section
  logic start; // event start this cycle
  logic fid_adv; // fiducial press advances the step
  assign start = (state_q == MSQ_IDLE) && (state_d == MSQ_FID) && !mc_p;
  assign fid_adv = (state_q == MSQ_FID) && fid_p && (step_q < FID_LAST) && !mc_p;

  // step counter drives the measurement display and relay choice
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      step_q <= 4'h0;
      fiducial_count <= FID_FIRST;
      fiducial_relay <= FID_FIRST;
      converter_enable <= 1'b0;
    end else if (mc_p) begin
      step_q <= 4'h0;
      fiducial_count <= FID_FIRST;
      fiducial_relay <= FID_FIRST;
      converter_enable <= 1'b0;
    end else if (start) begin
      step_q <= 4'h0;
      fiducial_count <= FID_FIRST; // RL5
      fiducial_relay <= msq_fid_num(4'h0); // RL6
      converter_enable <= 1'b1; // RL5
    end else if (fid_adv) begin
      step_q <= step_q + 4'h1;
      fiducial_count <= fiducial_count + 4'h1; // RL7
      fiducial_relay <= msq_fid_num(step_q + 4'h1); // RL2
      // no relay once the ninth fiducial is in
      converter_enable <= (step_q + 4'h1) < FID_LAST; // RL6
    end else if (state_q != MSQ_FID) begin
      converter_enable <= 1'b0;
    end
  end

  // trigger pulses toward the positioning timer
  logic vtx_trig; // combinational vertex trigger
  logic zone_trig; // combinational zone trigger
  assign vtx_trig = td_p && !mc_p && (((state_q == MSQ_FID) && step_q == FID_LAST)
                    || (state_q == MSQ_VTX)); // RL3
  assign zone_trig = vc_p && !mc_p && (state_q == MSQ_VTX) && !all_meas_q
                     && !last_vtx && !stage_hold; // RL19

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fid_counter_reset <= 1'b0;
      fiducial_trigger <= 1'b0;
      vertex_trigger <= 1'b0;
      zone_trigger <= 1'b0;
    end else begin
      fid_counter_reset <= start; // RL5
      fiducial_trigger <= start | fid_adv; // RL7
      vertex_trigger <= vtx_trig;
      zone_trigger <= zone_trig;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // view counter: 2 -> 3 -> 1, holds at 1; a 0 would reload 2
  logic [1:0] view_q; // measurement view counter
  logic view_chg; // view change pulse
  assign view_chg = vtx_wrap && (view_q != VIEW_LAST) && !mc_p;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      view_q <= VIEW_LOAD;
    end else if (mc_p || start) begin
      view_q <= VIEW_LOAD; // RL8
    end else if (view_q == VIEW_WRAP) begin
      view_q <= VIEW_LOAD; // RL8
    end else if (view_chg) begin
      // counting up keeps the 2, 3, 1 order; 1 never advances here
      view_q <= (view_q == 2'h3) ? 2'h1 : view_q + 2'h1; // RL15
    end
  end

  // view display follows the fiducial pairing, then the counter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      view_number <= VIEW_LOAD;
    end else if (state_q == MSQ_FID) begin
      view_number <= msq_fid_view(step_q < FID_LAST ? step_q : 4'h8); // RL2
    end else begin
      view_number <= view_q; // RL20
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // vertex counters
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      vertex_total <= '0;
      vertex_up <= UP_FIRST;
      vertex_down <= '0;
      all_meas_q <= 1'b0;
    end else if (mc_p) begin
      vertex_total <= '0;
      vertex_up <= UP_FIRST;
      vertex_down <= '0;
      all_meas_q <= 1'b0;
    end else if (start) begin
      vertex_total <= card_vertex_count; // RL20
      vertex_down <= card_vertex_count; // RL14
      vertex_up <= UP_FIRST; // RL14
      all_meas_q <= 1'b0;
    end else if (vtx_wrap && view_q == VIEW_LAST) begin
      vertex_down <= '0; // RL13
      all_meas_q <= 1'b1;
    end else if (vtx_wrap) begin
      vertex_up <= UP_FIRST; // RL15
      vertex_down <= vertex_total; // RL15
    end else if ((state_q == MSQ_VTX) && vc_p && !all_meas_q) begin
      vertex_up <= vertex_up + UP_FIRST; // RL13
      vertex_down <= vertex_down - UP_FIRST; // RL13
    end
  end

  // measurement number and card zone column of the current vertex
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      measurement_number <= 4'h0;
      zone_column <= '0;
      zone_column_en <= 1'b0;
    end else begin
      measurement_number <= step_q; // RL20
      zone_column <= vertex_up; // RL17
      zone_column_en <= (state_q == MSQ_VTX) && !all_meas_q; // RL17
    end
  end

  // end-of-event enables
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      event_done_enable <= 1'b0;
      fiducial_return_enable <= 1'b0;
    end else begin
      fiducial_return_enable <= last_vtx && !mc_p; // RL16
      // enabled by the last vertex complete, held until the event ends
      event_done_enable <= !mc_p && (state_q == MSQ_VTX) && (state_d == MSQ_VTX)
                           && (all_meas_q || (vtx_wrap && view_q == VIEW_LAST)); // RL13
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // automatic mode with retriggerable drop-out timer
  logic any_count; // any encoder direction pulse
  logic auto_set; // any trigger this cycle
  logic [HW-1:0] hold_q; // cycles left before drop-out
  assign any_count = x_add | x_sub | y_add | y_sub; // RL10
  assign auto_set = start | fid_adv | vtx_trig | zone_trig; // RL9

  // joystick wins over a trigger so the operator keeps control
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      auto_mode <= 1'b0;
      hold_q <= '0;
    end else if (joystick_active || mc_p) begin
      auto_mode <= 1'b0; // RL11
      hold_q <= '0;
    end else if (auto_set) begin
      auto_mode <= 1'b1; // RL9
      hold_q <= HOLD_LOAD;
    end else if (auto_mode && any_count) begin
      hold_q <= HOLD_LOAD; // RL10
    end else if (auto_mode && hold_q == '0) begin
      auto_mode <= 1'b0; // RL10
    end else if (auto_mode) begin
      hold_q <= hold_q - 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // return-to-vertex clutches: engaged once the stage settles at the vertex
  logic auto_prev_q; // auto mode last cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      auto_prev_q <= 1'b0;
      clutch_engage <= 1'b0;
    end else begin
      auto_prev_q <= auto_mode;
      if (mc_p || state_q != MSQ_VTX || td_p || vc_p || all_meas_q) begin
        clutch_engage <= 1'b0; // release lets the memory pot spring back
      end else if (auto_prev_q && !auto_mode) begin
        clutch_engage <= 1'b1; // RL12
      end
    end
  end

endmodule // msq_sequencer

// ---- tb/msq_sequencer_sva.sv ----
// port assertions for the measurement sequencer
// assumes one clock domain; bound into every msq_sequencer below
`timescale 1ns/1ns
module msq_sequencer_sva #(
  parameter int VW = 4,
  parameter int AUTO_HOLD = 20
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic joystick_active,
  input wire logic x_add,
  input wire logic x_sub,
  input wire logic y_add,
  input wire logic y_sub,
  input wire logic converter_enable,
  input wire logic fid_counter_reset,
  input wire logic fiducial_trigger,
  input wire logic vertex_trigger,
  input wire logic zone_trigger,
  input wire logic [3:0] fiducial_count,
  input wire logic auto_mode,
  input wire logic event_discard,
  input wire logic event_done_enable,
  input wire logic cycle_end,
  input wire logic [1:0] view_number,
  input wire logic [VW-1:0] vertex_total,
  input wire logic [VW-1:0] vertex_down,
  input wire logic [VW-1:0] vertex_up,
  input wire logic [VW-1:0] zone_column,
  input wire logic zone_column_en
);
  logic [15:0] quiet_q; // cycles in auto with no pulse or trigger
  logic kick; // anything that restarts the hold time
  assign kick = x_add | x_sub | y_add | y_sub | fiducial_trigger | vertex_trigger | zone_trigger;
  // counting in helper logic keeps the long hold out of a repetition
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) quiet_q <= 16'h0;
    else if (kick || !auto_mode) quiet_q <= 16'h0;
    else quiet_q <= quiet_q + 16'h1;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_fid_pulse;
    fiducial_trigger ##1 !fiducial_trigger;
  endsequence
  property p_fid_pulse; fiducial_trigger |-> s_fid_pulse; endproperty
  a_fid_pulse: assert property (p_fid_pulse) else $error("fiducial trigger too long");
  property p_fid_reset; fid_counter_reset |-> fiducial_count == 4'h1 && converter_enable
    && fiducial_trigger; endproperty
  a_fid_reset: assert property (p_fid_reset) else $error("fiducial reset bad");
  property p_fid_step; fiducial_trigger && !fid_counter_reset
    |-> fiducial_count == $past(fiducial_count) + 4'h1; endproperty
  a_fid_step: assert property (p_fid_step) else $error("fiducial count not advanced");
  property p_view_nz; view_number != 2'h0; endproperty
  a_view_nz: assert property (p_view_nz) else $error("view shows zero");
  property p_auto_set; (fiducial_trigger || vertex_trigger || zone_trigger)
    && !$past(joystick_active) |-> auto_mode; endproperty
  a_auto_set: assert property (p_auto_set) else $error("trigger did not set auto");
  property p_auto_drop; auto_mode |-> quiet_q <= AUTO_HOLD + 3; endproperty
  a_auto_drop: assert property (p_auto_drop) else $error("auto mode held too long");
  property p_joy; joystick_active |=> !auto_mode; endproperty
  a_joy: assert property (p_joy) else $error("joystick did not clear auto");
  property p_zone_last; zone_trigger |-> !event_done_enable; endproperty
  a_zone_last: assert property (p_zone_last) else $error("zone after last vertex");
  property p_end_ok; cycle_end |-> $past(event_done_enable); endproperty
  a_end_ok: assert property (p_end_ok) else $error("event done taken early");
  property p_down; vertex_down <= vertex_total; endproperty
  a_down: assert property (p_down) else $error("down count above total");
  property p_col; zone_column_en && $past(zone_column_en) |-> zone_column == $past(vertex_up);
  endproperty
  a_col: assert property (p_col) else $error("zone column mismatch");
  property p_disc; event_discard |=> !event_discard; endproperty
  a_disc: assert property (p_disc) else $error("discard too long");
endmodule // msq_sequencer_sva
bind msq_sequencer msq_sequencer_sva #(.VW(VW), .AUTO_HOLD(AUTO_HOLD)) i_msq_sequencer_sva (.*);

// ---- tb/msq_operator.sv ----
// operator and stage model: buttons, stage hold, joystick, encoder pulses
// assumes the bench calls press and set_level from its main sequence
`timescale 1ns/1ns
module msq_operator (
  input wire logic clk,
  input wire logic auto_mode,
  output logic [8:0] btn,
  output logic [3:0] enc
);
  logic prev_q; // auto mode one cycle ago
  int left; // pulses still to come in this move
  int tick; // free cycle count for pulse spacing
  initial begin
    btn = 9'h0;
    enc = 4'h0;
    prev_q = 1'b0;
    left = 0;
    tick = 0;
  end
  // press held two cycles, then low, so one press gives one pulse
  task automatic press(input int b);
    @(posedge clk);
    #1 btn[b] = 1'b1;
    repeat (2) @(posedge clk);
    #1 btn[b] = 1'b0;
  endtask
  // level inputs: stage hold and joystick
  task automatic set_level(input int b, input logic v);
    @(posedge clk);
    #1 btn[b] = v;
  endtask
  // stage travel: a short random burst per move, then it stands still
  always @(posedge clk) begin
    #1;
    enc = 4'h0;
    if (auto_mode && !prev_q) left = $urandom_range(6, 2);
    if (!auto_mode) left = 0;
    tick = tick + 1;
    if (left > 0 && tick % 4 == 0) begin
      enc[$urandom_range(3, 0)] = 1'b1;
      left = left - 1;
    end
    prev_q = auto_mode;
  end
endmodule // msq_operator

// ---- tb/measurement_sequencer_tb.sv ----
// self-checking bench for the measurement sequencer
// assumes msq_pkg, msq_sequencer and the operator model are compiled first
`timescale 1ns/1ns
module measurement_sequencer_tb;
  import msq_pkg::*;
  localparam int VW = 4;
  logic clk, rst_n, master_clear, indicative_data_strobe, fiducial_press, track_done;
  logic vertex_complete, event_done, stage_hold, card_open, joystick_active;
  logic x_add, x_sub, y_add, y_sub, converter_enable, fid_counter_reset, fiducial_trigger;
  logic vertex_trigger, zone_trigger, auto_mode, clutch_engage, event_discard;
  logic event_done_enable, fiducial_return_enable, cycle_end, zone_column_en;
  logic [3:0] fiducial_count, fiducial_relay, measurement_number;
  logic [1:0] view_number;
  logic [VW-1:0] card_vertex_count, vertex_total, vertex_up, vertex_down, zone_column;
  logic [8:0] btn;
  logic [4:0] exp_q [$]; // pulse patterns still awaited
  logic [4:0] seen, e;
  int failures = 0, tests_run = 0, n, last, hold;
  int fv [9] = '{2, 3, 1, 3, 1, 2, 3, 1, 2};
  int vs [3] = '{2, 3, 1};
  assign {stage_hold, joystick_active, card_open, event_done, vertex_complete, track_done,
    fiducial_press, indicative_data_strobe, master_clear} = btn;
  assign seen = {fiducial_trigger, vertex_trigger, zone_trigger, cycle_end, event_discard};
  msq_sequencer #(.VW(VW), .AUTO_HOLD(20)) i_msq_sequencer (.*);
  msq_operator i_msq_operator (.clk(clk), .auto_mode(auto_mode), .btn(btn),
    .enc({y_sub, y_add, x_sub, x_add}));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] g, input logic [7:0] x);
    tests_run++;
    if (g !== x) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, x, g);
    end
  endtask
  // pulses are one cycle wide; mid-cycle sampling sees each exactly once
  always @(negedge clk) begin
    if (seen !== 5'h0) begin
      tests_run++;
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 5'h0;
      if (seen !== e) begin
        failures++;
        $display("[FAIL] pulses expected %b seen %b", e, seen);
      end
    end
  end
  // press, note the expected pulses, wait for the stage to settle
  task automatic step(input int b, input logic [4:0] x);
    int i;
    if (x != 5'h0) exp_q.push_back(x);
    i_msq_operator.press(b);
    repeat (4) @(posedge clk);
    for (i = 0; i < 400 && auto_mode !== 1'b0; i++) @(posedge clk);
    if (i == 400) begin
      failures++;
      $display("[FAIL] auto drop expected 0 seen %b", auto_mode);
      finish_test();
    end
    repeat (3) @(posedge clk);
    #1 chk("pulse queue", exp_q.size(), 0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    card_vertex_count = '0;
    void'($urandom(32'h026a));
    repeat (3) @(posedge clk);
    #1 rst_n = 1'b1;
    chk("fid count", fiducial_count, 8'h01);
    chk("view", view_number, 8'h02);
    chk("vertex up", vertex_up, 8'h01);
    n = $urandom_range(3, 2);
    card_vertex_count = n;
    step(3, 5'h00);
    step(1, 5'h10);
    chk("conv en", converter_enable, 8'h01);
    chk("total", vertex_total, n);
    chk("down", vertex_down, n);
    step(3, 5'h00);
    for (int k = 0; k < 9; k++) begin
      chk("fid count", fiducial_count, k + 1);
      chk("relay", fiducial_relay, (k < 8) ? k + 1 : 2);
      chk("view", view_number, fv[k]);
      chk("meas", measurement_number, k);
      step(2, 5'h10);
    end
    chk("conv en", converter_enable, 8'h00);
    step(2, 5'h00);
    step(3, 5'h08);
    for (int vi = 0; vi < 3; vi++) begin
      for (int j = 1; j <= n; j++) begin
        last = (vi == 2 && j == n);
        hold = (vi == 1 && j == 1);
        chk("view", view_number, vs[vi]);
        chk("vertex up", vertex_up, j);
        chk("down", vertex_down, n - j + 1);
        chk("zone col", zone_column, j);
        chk("zone en", zone_column_en, 8'h01);
        chk("return en", fiducial_return_enable, last);
        if (vi == 0 && j == 1) step(5, 5'h00);
        step(3, 5'h08);
        chk("clutch", clutch_engage, 8'h01);
        i_msq_operator.set_level(8, hold);
        step(4, (last || hold) ? 5'h00 : 5'h04);
        i_msq_operator.set_level(8, 1'b0);
      end
    end
    chk("done en", event_done_enable, 8'h01);
    chk("zone en", zone_column_en, 8'h00);
    step(5, 5'h02);
    chk("done en", event_done_enable, 8'h00);
    exp_q.push_back(5'h10);
    i_msq_operator.press(1);
    repeat (2) @(posedge clk);
    #1 chk("auto", auto_mode, 8'h01);
    i_msq_operator.set_level(7, 1'b1);
    @(posedge clk);
    #1 chk("auto", auto_mode, 8'h00);
    i_msq_operator.set_level(7, 1'b0);
    step(6, 5'h01);
    step(0, 5'h00);
    chk("view", view_number, 8'h02);
    chk("conv en", converter_enable, 8'h00);
    finish_test();
  end
endmodule // measurement_sequencer_tb
